// file: hw/fsc_cmd.sv
// Purpose: ID, parameter table, security register and block lock commands
// Assumes: sclk at most mclk/8; pins synchronised here
// Notes: Status reads and other opcodes live elsewhere
`timescale 1ns/1ns
`include "fsc_defines.svh"

module fsc_cmd #(
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] TYPE_ID = 8'h40, // Arbitrary value
	parameter logic [7:0] SIZE_ID = 8'h20, // Arbitrary value
	parameter int BLK_W = 10,
	parameter int ERASE_CYCLES = `FSC_ERASE_TIME_US * `FSC_CLK_MHZ
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic di,
	output logic dout,
	output logic dout_oe,
	input wire logic write_enable_latch,
	output logic wel_clear,
	input wire logic busy_in,
	output logic busy,
	input wire logic addr_4byte,
	input wire logic [2:0] otp_lock_bits,
	input wire logic protect_scheme_select,
	input wire logic protect_complement,
	input wire logic protect_top_bottom,
	input wire logic [3:0] protect_block_range,
	input wire logic [31:0] prot_query_addr,
	output logic prot_locked
);
	localparam int NUM_BLK = 1 << BLK_W;
	localparam int EW = $clog2(ERASE_CYCLES + 1);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic cs_s1, cs_s2, cs_d, ck_s1, ck_s2, ck_d, di_s1, di_s2;
	logic rise, fall, frame_end;

	// Two flops per pin, then a delay flop for edges
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_d <= 1'b1;
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_d <= 1'b0;
			di_s1 <= 1'b0;
			di_s2 <= 1'b0;
		end
		else
		begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			cs_d <= cs_s2;
			ck_s1 <= sclk;
			ck_s2 <= ck_s1;
			ck_d <= ck_s2;
			di_s1 <= di;
			di_s2 <= di_s1;
		end
	end

	// Clock edges seen only while selected; frame end on deselect
	assign rise = ck_s2 & ~ck_d & ~cs_s2;
	assign fall = ~ck_s2 & ck_d & ~cs_s2;
	assign frame_end = cs_s2 & ~cs_d;

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	fsc_pkg::fsc_state_t state, next_state;
	logic [7:0] opcode, next_opcode, sh, next_sh, rd_ptr, next_rd_ptr;
	logic [6:0] bitcnt, next_bitcnt, bit_inc, alen, addr_end, dummy_end;
	logic [31:0] addr, next_addr;
	logic [2:0] obit, next_obit;
	logic next_dout, next_dout_oe, busy_any;
	logic sec_ok, sec_locked, erase_go, lock_go, prog_we;
	logic [1:0] sec_idx;
	logic [7:0] prog_byte;
	// Security memory, three registers back to back
	logic [7:0] mem [3*256];
	// Read path buffer
	logic push_valid, push_ready, pop_valid, pop_ready;
	logic [7:0] push_data, pop_data;
	// Erase engine
	logic er_active, next_er_active, next_wel_clear;
	logic [EW-1:0] er_cnt, next_er_cnt;
	logic [1:0] er_sel, next_er_sel;

	assign busy_any = er_active | busy_in;
	assign bit_inc = (bitcnt == `FSC_BIT_SAT) ? bitcnt : bitcnt + 7'd1;
	// Table read is fixed at three address bytes
	assign alen = (opcode == `FSC_OP_READ_TABLE || !addr_4byte) ?
		`FSC_ADDR3_BITS : `FSC_ADDR4_BITS;
	assign addr_end = `FSC_OP_BITS + alen;
	assign dummy_end = addr_end + `FSC_DUMMY_BITS;

	// Register select: pad bits must be zero
	assign sec_ok = addr[31:`FSC_SEC_HIGH_LSB] == '0 &&
		addr[`FSC_SEC_PAD_LSB +: 4] == 4'h0 &&
		addr[`FSC_SEC_SEL_LSB +: 4] >= `FSC_SEC_FIRST &&
		addr[`FSC_SEC_SEL_LSB +: 4] <= `FSC_SEC_LAST;
	assign sec_idx = 2'(addr[`FSC_SEC_SEL_LSB +: 4] - `FSC_SEC_FIRST);
	assign sec_locked = sec_ok && otp_lock_bits[sec_idx];
	assign prog_byte = {sh[6:0], di_s2};

	// Exact deselect after the last address bit
	assign erase_go = frame_end && state == fsc_pkg::FSC_ARMED &&
		opcode == `FSC_OP_SEC_ERASE && bitcnt == addr_end && sec_ok &&
		!sec_locked && write_enable_latch && !busy_any;
	assign lock_go = frame_end && state == fsc_pkg::FSC_ARMED &&
		opcode == `FSC_OP_BLOCK_LOCK && bitcnt == addr_end;
	// Program only clears bits of the stored byte
	assign prog_we = rise && state == fsc_pkg::FSC_PDATA && obit == 3'h7 &&
		sec_ok && !sec_locked && write_enable_latch;

	// Frame next state
	always_comb
	begin
		next_state = state;
		next_opcode = opcode;
		next_bitcnt = bitcnt;
		next_addr = addr;
		next_rd_ptr = rd_ptr;
		next_sh = sh;
		next_obit = obit;
		next_dout = dout;
		next_dout_oe = dout_oe;
		if (cs_s2)
		begin
			// Deselected: park for the next opcode
			next_state = fsc_pkg::FSC_OPCODE;
			next_bitcnt = 7'h0;
			next_addr = 32'h0;
			next_obit = 3'h0;
			next_dout_oe = 1'b0;
		end
		else if (rise)
		begin
			next_bitcnt = bit_inc;
			case (state)
				fsc_pkg::FSC_OPCODE:
				begin
					next_opcode = {opcode[6:0], di_s2};
					next_rd_ptr = 8'h0;
					if (bit_inc == `FSC_OP_BITS)
					begin
						// Busy device answers none of these
						if (busy_any)
							next_state = fsc_pkg::FSC_IGNORE;
						else if (next_opcode == `FSC_OP_READ_ID)
							next_state = fsc_pkg::FSC_OUT;
						else if (next_opcode == `FSC_OP_READ_TABLE ||
							next_opcode == `FSC_OP_SEC_ERASE ||
							next_opcode == `FSC_OP_SEC_PROG ||
							next_opcode == `FSC_OP_SEC_READ ||
							next_opcode == `FSC_OP_BLOCK_LOCK)
							next_state = fsc_pkg::FSC_ADDR;
						else
							next_state = fsc_pkg::FSC_IGNORE;
					end
				end
				fsc_pkg::FSC_ADDR:
				begin
					next_addr = {addr[30:0], di_s2};
					next_rd_ptr = {addr[6:0], di_s2};
					if (bit_inc == addr_end)
					begin
						if (opcode == `FSC_OP_SEC_PROG)
							next_state = fsc_pkg::FSC_PDATA;
						else if (opcode == `FSC_OP_SEC_READ ||
							opcode == `FSC_OP_READ_TABLE)
							next_state = fsc_pkg::FSC_DUMMY;
						else
							next_state = fsc_pkg::FSC_ARMED;
					end
				end
				fsc_pkg::FSC_DUMMY:
				begin
					// Table read reaches clock 40 here
					if (bit_inc == dummy_end)
						next_state = fsc_pkg::FSC_OUT;
				end
				fsc_pkg::FSC_PDATA:
				begin
					next_sh = prog_byte;
					next_obit = obit + 3'h1;
					// Byte pointer wraps within the register
					if (obit == 3'h7)
						next_rd_ptr = rd_ptr + 8'h1;
				end
				default:
				begin
					next_state = state;
				end
			endcase
		end
		else if (fall && state == fsc_pkg::FSC_OUT)
		begin
			// MSB first; an empty buffer reads as erased
			next_dout_oe = 1'b1;
			if (obit == 3'h0)
			begin
				next_dout = pop_valid ? pop_data[7] : 1'b1;
				next_sh = pop_valid ? {pop_data[6:0], 1'b0} : `FSC_ERASED_BYTE;
				next_obit = 3'h7;
			end
			else
			begin
				next_dout = sh[7];
				next_sh = {sh[6:0], 1'b0};
				next_obit = obit - 3'h1;
			end
		end
	end

	// Register frame state
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state <= fsc_pkg::FSC_OPCODE;
			opcode <= 8'h0;
			bitcnt <= 7'h0;
			addr <= 32'h0;
			rd_ptr <= 8'h0;
			sh <= 8'h0;
			obit <= 3'h0;
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			opcode <= next_opcode;
			bitcnt <= next_bitcnt;
			addr <= next_addr;
			rd_ptr <= push_valid && push_ready ? rd_ptr + 8'h1 : next_rd_ptr;
			sh <= next_sh;
			obit <= next_obit;
			dout <= next_dout;
			dout_oe <= next_dout_oe;
		end
	end

	// ----------------------------------------
	// Read data producer and buffer
	// ----------------------------------------
	// Prefetch during dummy clocks so the first bit is ready
	assign push_valid = state == fsc_pkg::FSC_DUMMY || state == fsc_pkg::FSC_OUT;
	assign pop_ready = fall && state == fsc_pkg::FSC_OUT && obit == 3'h0;

	// Byte source per opcode
	always_comb
	begin
		push_data = `FSC_ERASED_BYTE;
		case (opcode)
			`FSC_OP_READ_ID:
			begin
				if (rd_ptr == 8'h0)
					push_data = MAKER_ID;
				else if (rd_ptr == 8'h1)
					push_data = TYPE_ID;
				else if (rd_ptr == 8'h2)
					push_data = SIZE_ID;
			end
			`FSC_OP_READ_TABLE:
			begin
				// Signature, rest of table reads erased
				if (rd_ptr == 8'h0)
					push_data = `FSC_TBL_SIG0;
				else if (rd_ptr == 8'h1)
					push_data = `FSC_TBL_SIG1;
				else if (rd_ptr == 8'h2)
					push_data = `FSC_TBL_SIG2;
				else if (rd_ptr == 8'h3)
					push_data = `FSC_TBL_SIG3;
			end
			`FSC_OP_SEC_READ:
			begin
				if (sec_ok)
					push_data = mem[{sec_idx, rd_ptr}];
			end
			default:
			begin
				push_data = `FSC_ERASED_BYTE;
			end
		endcase
	end

	fsc_pair_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
		.mclk(mclk),
		.resetn(resetn),
		.flush(cs_s2),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_data)
	);

	// ----------------------------------------
	// Erase engine and memory writes
	// ----------------------------------------
	// Erase writes 256 bytes, then waits out the rest
	always_comb
	begin
		next_er_active = er_active;
		next_er_cnt = er_cnt;
		next_er_sel = er_sel;
		next_wel_clear = frame_end && opcode == `FSC_OP_SEC_PROG &&
			state == fsc_pkg::FSC_PDATA;
		if (!er_active)
		begin
			if (erase_go)
			begin
				next_er_active = 1'b1;
				next_er_cnt = '0;
				next_er_sel = sec_idx;
			end
		end
		else if (er_cnt == EW'(ERASE_CYCLES - 1))
		begin
			next_er_active = 1'b0;
			next_wel_clear = 1'b1;
		end
		else
			next_er_cnt = er_cnt + EW'(1);
	end

	// Register erase state
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			er_active <= 1'b0;
			er_cnt <= '0;
			er_sel <= 2'h0;
			wel_clear <= 1'b0;
		end
		else
		begin
			er_active <= next_er_active;
			er_cnt <= next_er_cnt;
			er_sel <= next_er_sel;
			wel_clear <= next_wel_clear;
		end
	end
	assign busy = er_active;

	// One write port; erase has priority
	always_ff @(posedge mclk)
	begin
		if (er_active && er_cnt < EW'(256))
			mem[{er_sel, er_cnt[7:0]}] <= `FSC_ERASED_BYTE;
		else if (prog_we)
			mem[{sec_idx, rd_ptr}] <= mem[{sec_idx, rd_ptr}] & prog_byte;
	end

	// ----------------------------------------
	// Block locks and protection query
	// ----------------------------------------
	logic [NUM_BLK-1:0] lock_bits, next_lock;
	logic [BLK_W-1:0] lock_idx, q_blk;
	logic [BLK_W:0] span;
	logic [3:0] bp_m1;
	logic range_hit;

	assign lock_idx = addr[`FSC_BLOCK_LSB +: BLK_W];
	generate
		for (genvar i = 0; i < NUM_BLK; i++)
		begin : g_lock
			assign next_lock[i] = lock_bits[i] | (lock_go && lock_idx == BLK_W'(i));
		end
	endgenerate

	// Range scheme: 2^(range-1) blocks from one end
	always_comb
	begin
		q_blk = prot_query_addr[`FSC_BLOCK_LSB +: BLK_W];
		bp_m1 = protect_block_range - 4'h1;
		span = (32'(bp_m1) >= BLK_W) ? (BLK_W+1)'(NUM_BLK) : (BLK_W+1)'(1) << bp_m1;
		if (protect_block_range == 4'h0)
			range_hit = 1'b0;
		else if (protect_top_bottom)
			range_hit = {1'b0, q_blk} < span;
		else
			range_hit = {1'b0, q_blk} >= (BLK_W+1)'(NUM_BLK) - span;
	end

	// Volatile locks start all set
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			lock_bits <= '1;
			prot_locked <= 1'b1;
		end
		else
		begin
			lock_bits <= next_lock;
			prot_locked <= protect_scheme_select ? lock_bits[q_blk] :
				range_hit ^ protect_complement;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_id_order;
		push_valid && push_ready && opcode == `FSC_OP_READ_ID && rd_ptr == 8'h1
			|-> push_data == TYPE_ID && $past(rd_ptr) <= 8'h1;
	endproperty
	a_id_order: assert property (p_id_order) else $error("id byte order");

	property p_table_start;
		$rose(state == fsc_pkg::FSC_OUT) && opcode == `FSC_OP_READ_TABLE |-> bitcnt == 7'd40;
	endproperty
	a_table_start: assert property (p_table_start) else $error("table late");

	property p_erase_wel;
		$rose(er_active) |-> $past(write_enable_latch) && !$past(sec_locked);
	endproperty
	a_erase_wel: assert property (p_erase_wel) else $error("erase gate");

	property p_erase_cs;
		$rose(er_active) |-> $past(bitcnt) == $past(addr_end) && $past(cs_s2);
	endproperty
	a_erase_cs: assert property (p_erase_cs) else $error("erase frame");

	property p_busy_end;
		$fell(busy) |-> $past(er_cnt) == EW'(ERASE_CYCLES - 1) && wel_clear;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy end");

	property p_wel_clear;
		$fell(er_active) |-> wel_clear ##1 !wel_clear;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch clear");

	// A refused program byte must leave the memory byte as it was
	property p_prog_lock;
		rise && state == fsc_pkg::FSC_PDATA && obit == 3'h7 && sec_ok && !er_active &&
			(otp_lock_bits[sec_idx] || !write_enable_latch)
			|=> mem[$past({sec_idx, rd_ptr})] == $past(mem[{sec_idx, rd_ptr}]);
	endproperty
	a_prog_lock: assert property (p_prog_lock) else $error("locked write");

	property p_wrap;
		push_valid && push_ready && opcode == `FSC_OP_SEC_READ && rd_ptr == 8'hff
			&& !rise |=> rd_ptr == 8'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");

	property p_busy_ignore;
		rise && state == fsc_pkg::FSC_OPCODE && bit_inc == `FSC_OP_BITS && busy_any
			|=> state == fsc_pkg::FSC_IGNORE ##1 !$rose(er_active);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("read while busy");

	property p_lock_reset;
		$past(!resetn) |-> &lock_bits;
	endproperty
	a_lock_reset: assert property (p_lock_reset) else $error("locks not set");

	property p_lock_set;
		lock_go |=> lock_bits[$past(lock_idx)];
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not set");

	c_id: cover property (pop_ready && opcode == `FSC_OP_READ_ID);
	c_table: cover property ($rose(state == fsc_pkg::FSC_OUT) && opcode == `FSC_OP_READ_TABLE);
	c_erase: cover property ($fell(er_active));
	c_lock: cover property (lock_go);
endmodule

// file: hw/fsc_defines.svh
// Purpose: Opcodes, field positions and timing for the command block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH
// Opcodes
`define FSC_OP_READ_ID 8'h9f
`define FSC_OP_READ_TABLE 8'h5a
`define FSC_OP_SEC_ERASE 8'h44
`define FSC_OP_SEC_PROG 8'h42
`define FSC_OP_SEC_READ 8'h48
`define FSC_OP_BLOCK_LOCK 8'h36
// Frame lengths in clocks
`define FSC_OP_BITS 7'd8
`define FSC_ADDR3_BITS 7'd24
`define FSC_ADDR4_BITS 7'd32
`define FSC_DUMMY_BITS 7'd8
`define FSC_BIT_SAT 7'h7f
// Address fields
`define FSC_SEC_SEL_LSB 12
`define FSC_SEC_PAD_LSB 8
`define FSC_SEC_HIGH_LSB 16
`define FSC_SEC_FIRST 4'h1
`define FSC_SEC_LAST 4'h3
`define FSC_BLOCK_LSB 16
// Contents
`define FSC_ERASED_BYTE 8'hff
`define FSC_TBL_SIG0 8'h53
`define FSC_TBL_SIG1 8'h46
`define FSC_TBL_SIG2 8'h44
`define FSC_TBL_SIG3 8'h50
// Timing
`define FSC_ERASE_TIME_US 50
`define FSC_CLK_MHZ 100
`endif

// file: hw/fsc_pair_buf.sv
// Purpose: Small valid/ready buffer in the read data path
// Assumes: One clock, synchronous reset
// Notes: Flush empties it at frame end
`timescale 1ns/1ns

module fsc_pair_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] slot [DEPTH]; // Storage, no reset needed
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// ----------------------------------------
	// Flags and pointers
	// ----------------------------------------
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = slot[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Next pointer values
	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (flush)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		else
		begin
			if (push)
				next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
			if (pop)
				next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
			// Simultaneous push and pop keep the count
			if (push && !pop)
				next_count = count + (AW+1)'(1);
			else if (pop && !push)
				next_count = count - (AW+1)'(1);
		end
	end

	// Register pointers
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Data slots
	always_ff @(posedge mclk)
	begin
		if (push && !flush)
			slot[wr_ptr] <= in_data;
	end
endmodule

// file: hw/fsc_pkg.sv
// Purpose: Types shared by the command block
// Assumes: Nothing
// Notes: Gray codes along opcode, address, dummy, output
package fsc_pkg;
	// Frame phase
	typedef enum logic [2:0] {
		FSC_OPCODE = 3'h0,
		FSC_ADDR = 3'h1,
		FSC_DUMMY = 3'h3,
		FSC_OUT = 3'h2,
		FSC_PDATA = 3'h6,
		FSC_ARMED = 3'h5,
		FSC_IGNORE = 3'h4
	} fsc_state_t;
endpackage

// file: testbench/fsc_host_model.sv
// Purpose: Host controller model that drives the serial link
// Assumes: SPI mode 0, sclk idle low, inputs launched just after mclk rises
// Notes: half_n sets sclk speed; raise it for a slow host, 4 is the fastest legal
`timescale 1ns/1ns

module fsc_host_model (
	input wire logic mclk,
	output logic cs_n,
	output logic sclk,
	output logic di,
	input wire logic dout,
	input wire logic dout_oe
);
	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	logic [7:0] tx_q[$]; // Bytes to send, first out first
	logic [7:0] rx_q[$]; // Bytes taken from dout
	logic oe_seen; // Device drove dout in this frame
	int half_n; // mclk cycles in one sclk half

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		di = 1'b0;
		oe_seen = 1'b0;
		half_n = 8;
	end

	// One sclk half, launched just after an mclk edge
	task automatic half();
		repeat (half_n) @(posedge mclk);
		#1;
	endtask

	// Whole frame: select, shift tx_q, clock in nrx bytes, deselect
	task automatic run(input int nrx);
		logic [7:0] b;
		rx_q = {};
		oe_seen = 1'b0;
		half();
		cs_n = 1'b0; // Held low to the last bit of every byte
		foreach (tx_q[i])
			for (int k = 7; k >= 0; k--)
			begin
				di = tx_q[i][k]; // MSB first, set while sclk is low
				half();
				sclk = 1'b1;
				half();
				sclk = 1'b0;
			end
		repeat (nrx)
		begin
			for (int k = 7; k >= 0; k--)
			begin
				di = ~di; // Unused input kept moving, so no stale level can help
				half();
				b[k] = dout; // Taken just before the rise, long after the fall
				oe_seen = oe_seen | dout_oe;
				sclk = 1'b1;
				half();
				sclk = 1'b0;
			end
			rx_q.push_back(b);
		end
		half();
		cs_n = 1'b1;
		di = ~di;
		half(); // Deselect gap well above 4 mclk
	endtask
endmodule

// file: testbench/tb_flash_id_security_lock_cmds.sv
// Purpose: Self-checking bench for the serial command block
// Assumes: Host model owns the link pins; bench plays the status logic
// Notes: Erase time cut to 300 mclk to keep the run short
`timescale 1ns/1ns
`include "fsc_defines.svh"

module tb_flash_id_security_lock_cmds;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
	localparam logic [7:0] KIND = 8'h71; // Arbitrary value
	localparam logic [7:0] SIZE = 8'h19; // Arbitrary value
	localparam int ERASE_N = 300; // Shortened erase
	localparam int BLK = 10; // Block index width
	localparam int NBLK = 1 << BLK; // Blocks in the array
	logic mclk, resetn, cs_n, sclk, di, dout, dout_oe, wel_clear, busy, prot_locked;
	logic write_enable_latch, busy_in, addr_4byte, protect_scheme_select;
	logic protect_complement, protect_top_bottom;
	logic [2:0] otp_lock_bits;
	logic [3:0] protect_block_range;
	logic [31:0] prot_query_addr;
	int fails, total_checks;
	int wel_pulses = 0; // Written only by the counter process
	int busy_len = 0; // Written only by the counter process

	fsc_cmd #(.MAKER_ID(MAKER), .TYPE_ID(KIND), .SIZE_ID(SIZE), .BLK_W(BLK),
		.ERASE_CYCLES(ERASE_N)) dut_u (
		.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .di(di), .dout(dout),
		.dout_oe(dout_oe), .write_enable_latch(write_enable_latch), .wel_clear(wel_clear),
		.busy_in(busy_in), .busy(busy), .addr_4byte(addr_4byte), .otp_lock_bits(otp_lock_bits),
		.protect_scheme_select(protect_scheme_select), .protect_complement(protect_complement),
		.protect_top_bottom(protect_top_bottom), .protect_block_range(protect_block_range),
		.prot_query_addr(prot_query_addr), .prot_locked(prot_locked));

	fsc_host_model host_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .di(di), .dout(dout),
		.dout_oe(dout_oe));

	// 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Pulse and busy-length counters
	always @(posedge mclk)
	begin
		if (wel_clear === 1'b1)
			wel_pulses <= wel_pulses + 1;
		if (busy === 1'b1)
			busy_len <= busy_len + 1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	task automatic expect_rx(input string nm, input logic [7:0] e[$]);
		foreach (e[i])
			chk(nm, e[i], host_u.rx_q[i]);
	endtask

	task automatic at();
		@(posedge mclk);
		#1;
	endtask

	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask

	// Opcode, na address bytes MSB first, nd dummy bytes
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd);
		host_u.tx_q = {op};
		for (int i = na - 1; i >= 0; i--)
			host_u.tx_q.push_back(a[8 * i +: 8]);
		repeat (nd) host_u.tx_q.push_back(8'h00);
	endtask

	task automatic prog(input logic [31:0] a, input logic [7:0] d[$]);
		cmd(`FSC_OP_SEC_PROG, a, 3, 0);
		foreach (d[i]) host_u.tx_q.push_back(d[i]);
		host_u.run(0);
	endtask

	task automatic sec_read(input logic [31:0] a, input int na, input int n);
		cmd(`FSC_OP_SEC_READ, a, na, 1);
		host_u.run(n);
	endtask

	// Bounded wait; a stuck busy shows up in the span check
	task automatic wait_idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++)
			@(posedge mclk);
		repeat (4) @(posedge mclk);
		#1;
	endtask

	// Erase frame; ok says whether it must run, probe tries a read meanwhile
	task automatic erase(input logic [31:0] a, input int na, input logic ok, input logic probe);
		int c0;
		int b0;
		c0 = wel_pulses;
		b0 = busy_len;
		cmd(`FSC_OP_SEC_ERASE, a, na, 0);
		host_u.run(0);
		chk("busy_start", ok, busy);
		if (probe)
		begin
			host_u.half_n = 4;
			sec_read(a, 3, 1); // Full frame, so only the busy refusal keeps dout quiet
			host_u.half_n = 8;
			chk("read_while_busy", 0, host_u.oe_seen);
		end
		wait_idle();
		chk("busy_span", ok, busy_len - b0 >= ERASE_N - 1 && busy_len - b0 <= ERASE_N + 1);
		chk("wel_clear_pulses", ok, wel_pulses - c0);
	endtask

	// Range scheme sweep; prot_locked is one cycle behind its inputs
	task automatic range_sweep();
		int span;
		int blk;
		logic hit;
		for (int r = 0; r < 16; r++)
			for (int q = 0; q < 3; q++)
				for (int m = 0; m < 4; m++)
				begin
					span = (r == 0) ? 0 : (r > BLK) ? NBLK : 1 << (r - 1);
					blk = (q == 2) ? NBLK - 1 : q;
					hit = m[1] ? blk < span : blk >= NBLK - span;
					protect_block_range = 4'(r);
					protect_top_bottom = m[1];
					protect_complement = m[0];
					prot_query_addr = 32'(blk) << `FSC_BLOCK_LSB;
					at();
					chk("range_sweep", hit ^ m[0], prot_locked);
				end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Tests take about 16k mclk; this limit means a hang
	initial
	begin
		repeat (90000) @(posedge mclk);
		fails++;
		summarize();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		write_enable_latch = 1'b0;
		busy_in = 1'b0;
		addr_4byte = 1'b0;
		otp_lock_bits = 3'h0;
		protect_scheme_select = 1'b1;
		protect_complement = 1'b0;
		protect_top_bottom = 1'b0;
		protect_block_range = 4'h0;
		prot_query_addr = 32'h0;
		fails = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		#1;
		resetn = 1'b1;
		at();
		chk("locked_after_reset", 1, prot_locked);
		chk("busy_after_reset", 0, busy);
		done("reset");
		cmd(`FSC_OP_READ_ID, 0, 0, 0);
		host_u.run(3);
		expect_rx("id", '{MAKER, KIND, SIZE});
		chk("oe_after_frame", 0, dout_oe);
		done("identity");
		cmd(`FSC_OP_READ_TABLE, 32'h2, 3, 1);
		host_u.run(3);
		expect_rx("table", '{`FSC_TBL_SIG2, `FSC_TBL_SIG3, `FSC_ERASED_BYTE});
		addr_4byte = 1'b1;
		host_u.half_n = 12; // Slow host
		cmd(`FSC_OP_READ_TABLE, 32'h0, 3, 1);
		host_u.run(2);
		expect_rx("table_4byte", '{`FSC_TBL_SIG0, `FSC_TBL_SIG1});
		host_u.half_n = 8;
		addr_4byte = 1'b0;
		busy_in = 1'b1;
		cmd(`FSC_OP_READ_ID, 0, 0, 0);
		host_u.run(1);
		chk("ignored_when_busy", 0, host_u.oe_seen);
		busy_in = 1'b0;
		done("table");
		erase(32'h1000, 3, 1'b0, 1'b0); // Latch clear
		write_enable_latch = 1'b1;
		erase(32'h1000, 4, 1'b0, 1'b0); // One address byte too many
		erase(32'h1100, 3, 1'b0, 1'b0); // Pad nibble not zero
		erase(32'h4000, 3, 1'b0, 1'b0); // No fourth register
		erase(32'h1000, 3, 1'b1, 1'b0);
		erase(32'h2055, 3, 1'b1, 1'b1); // Low bits ignored
		erase(32'h3000, 3, 1'b1, 1'b0);
		done("erase");
		prog(32'h10fe, '{8'ha5, 8'h3c});
		prog(32'h1000, '{8'h5a});
		write_enable_latch = 1'b0;
		prog(32'h1001, '{8'h00}); // Dropped with latch clear
		write_enable_latch = 1'b1;
		sec_read(32'h10fe, 3, 4);
		expect_rx("wrap_read", '{8'ha5, 8'h3c, 8'h5a, 8'hff});
		addr_4byte = 1'b1;
		sec_read(32'h30fe, 4, 2);
		expect_rx("other_reg_4byte", '{8'hff, 8'hff});
		addr_4byte = 1'b0;
		done("program");
		otp_lock_bits = 3'b010;
		prog(32'h2000, '{8'h00});
		sec_read(32'h2000, 3, 1);
		expect_rx("locked_prog", '{8'hff});
		for (int i = 0; i < 3; i++)
		begin
			otp_lock_bits = 3'(1 << i);
			erase(32'(i + 1) << `FSC_SEC_SEL_LSB, 3, 1'b0, 1'b0);
		end
		done("otp_lock");
		protect_scheme_select = 1'b0;
		at();
		at();
		chk("range_none", 0, prot_locked);
		protect_block_range = 4'h1;
		protect_top_bottom = 1'b1;
		at();
		at();
		chk("range_bottom_hit", 1, prot_locked);
		prot_query_addr = 32'h0001_0000;
		at();
		at();
		chk("range_bottom_miss", 0, prot_locked);
		protect_complement = 1'b1;
		at();
		at();
		chk("range_complement", 1, prot_locked);
		range_sweep();
		protect_scheme_select = 1'b1;
		cmd(`FSC_OP_BLOCK_LOCK, 32'h0001_0000, 3, 0);
		host_u.run(0);
		chk("block_locked", 1, prot_locked);
		done("protection");
		summarize();
	end
endmodule
